//--- ctm_pin_load.sv
module ctm_pin_load
(
   input wire logic pclk,
   input wire logic timer_out,
   input wire logic timer_out_en,
   output logic pin_level
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************************
   // Unpulled pin load
   // ****************************************************
   logic last_q;
   // No pull: a released pin shows the inverse of the last level
   always_ff @(posedge pclk)
      if (!timer_out_en)
         last_q <= timer_out;
   assign pin_level = timer_out_en ? ~last_q : timer_out;
endmodule : ctm_pin_load

//--- ctm_pkg.sv
package ctm_pkg;

   // ***************************************************************
   // Register map (byte addresses, one aligned word each)
   // ***************************************************************
   localparam logic [11:0] ADDR_CTRL0 = 12'h000;
   localparam logic [11:0] ADDR_CTRL1 = 12'h004;
   localparam logic [11:0] ADDR_CNT = 12'h008;
   localparam logic [11:0] ADDR_CMPA = 12'h00C;
   localparam logic [11:0] ADDR_CMPP = 12'h010;
   localparam logic [11:0] ADDR_FLAGS = 12'h014;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int RUN_POS = 3;
   localparam int MODE_HI_POS = 7;
   localparam int MODE_LO_POS = 6;
   localparam int PFUNC_HI_POS = 5;
   localparam int PFUNC_LO_POS = 4;
   localparam int OLC_POS = 3;
   localparam int INV_POS = 2;
   localparam int SWAP_POS = 1;
   localparam int CLRSEL_POS = 0;
   localparam int FLAG_A_POS = 0;
   localparam int FLAG_P_POS = 1;

   // ***************************************************************
   // Widths, reset values and counts
   // ***************************************************************
   localparam int CNT_W = 10;
   localparam int CMPP_W = 3;
   localparam logic [9:0] CNT_MAX = 10'h3FF;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [9:0] CNT_RST = 10'h000;
   localparam logic [11:0] FULL_PERIOD = 12'h400;
   localparam int P_SHIFT = 7;

   // ***************************************************************
   // Modes and pin functions
   // ***************************************************************
   typedef enum logic [1:0]
   {
      MODE_CMP = 2'b00,
      MODE_UNDEF = 2'b01,
      MODE_PWM = 2'b10,
      MODE_TMR = 2'b11
   } ctm_mode_t;

   localparam logic [1:0] PF_NONE = 2'b00;
   localparam logic [1:0] PF_LOW = 2'b01;
   localparam logic [1:0] PF_HIGH = 2'b10;
   localparam logic [1:0] PF_TOGGLE = 2'b11;
   localparam logic [1:0] PF_INACT = 2'b00;
   localparam logic [1:0] PF_ACT = 2'b01;
   localparam logic [1:0] PF_WAVE = 2'b10;

endpackage : ctm_pkg

//--- ctm_timer.sv
// Notes on behaviour
// - Mode field 00 selects compare-match output mode.
// - Mode 11 is timer mode: same counting and flags, pin never driven.
// - Mode field 10 selects PWM output mode.
// - Clear-select low: clear on P match or overflow if P zero; both flags.
// - Clear-select high: clear on A match, only A flag ever set.
// - A value zero: counter overflows at 3FF, no A flag.
// - Compare mode: pin changes only on A match or run rising, never on P match.
// - Pin function picks high, low or toggle on A match; zero means none.
// - Run bit rising loads pin with initial level from output control.
// - PWM ignores clear-select; swap bit picks period and duty register.
// - Swap 0: period P*128 or 1024 when P zero; duty is A.
// - Swap 1: period is A+1 counts (clear on A match); duty P*128 or 1024 when P zero.
// - Duty at or above period gives output active whole period.
// - PWM sets A flag on each A match, P flag on each P match.
// - PWM active level from output control, pin function gates, invert.
// - PWM counter and compares run while pin forced inactive or active.
// - P value compares against counter bits 9 to 7 only.
// - Run rising zeroes counter; run falling holds counter value.
// - PWM pin function: 00 inactive, 01 active, 10 waveform, 11 undefined.
module ctm_timer
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic timer_out,
   output logic timer_out_en
);

   // ***************************************************************
   // Registers
   // ***************************************************************
   logic run_q;
   logic [7:0] ctrl1_q;
   logic [9:0] cmpa_q;
   logic [2:0] cmpp_q;
   logic [9:0] cnt_q;
   logic match_a_flag_q;
   logic match_p_flag_q;
   logic pin_q;
   logic wave_q;
   logic run_rise;
   logic wr_en;
   logic rd_hit;
   ctm_pkg::ctm_mode_t mode;
   logic [1:0] pfunc;
   logic olc;
   logic inv;
   logic swap;
   logic clrsel;
   logic a_eq;
   logic p_eq;
   logic a_match;
   logic p_match;
   logic cnt_clear;
   logic [11:0] p_len;
   logic [11:0] period;
   logic [11:0] duty;
   logic [11:0] cnt_ext;

   assign mode = ctm_pkg::ctm_mode_t'(ctrl1_q[ctm_pkg::MODE_HI_POS:
                                              ctm_pkg::MODE_LO_POS]);
   assign pfunc = ctrl1_q[ctm_pkg::PFUNC_HI_POS:ctm_pkg::PFUNC_LO_POS];
   assign olc = ctrl1_q[ctm_pkg::OLC_POS];
   assign inv = ctrl1_q[ctm_pkg::INV_POS];
   assign swap = ctrl1_q[ctm_pkg::SWAP_POS];
   assign clrsel = ctrl1_q[ctm_pkg::CLRSEL_POS];

   // ***************************************************************
   // APB slave: zero wait states, unmapped reads zero, no error
   // ***************************************************************
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign wr_en = psel && penable && pwrite;
   assign rd_hit = psel && !pwrite;

   // Run bit edge: a write that raises it restarts the cycle
   assign run_rise = wr_en && (paddr == ctm_pkg::ADDR_CTRL0) &&
                     pwdata[ctm_pkg::RUN_POS] && !run_q;

   // Control and compare registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         run_q <= 1'b0;
         ctrl1_q <= ctm_pkg::CTRL_RST;
         cmpa_q <= ctm_pkg::CNT_RST;
         cmpp_q <= 3'h0;
      end
      else if (wr_en)
      begin
         if (paddr == ctm_pkg::ADDR_CTRL0)
            run_q <= pwdata[ctm_pkg::RUN_POS];
         else if (paddr == ctm_pkg::ADDR_CTRL1)
            ctrl1_q <= pwdata[7:0];
         else if (paddr == ctm_pkg::ADDR_CMPA)
            cmpa_q <= pwdata[9:0];
         else if (paddr == ctm_pkg::ADDR_CMPP)
            cmpp_q <= pwdata[2:0];
      end
   end

   // Read mux, registered in the setup cycle so data is ready at access
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (rd_hit && !penable)
      begin
         if (paddr == ctm_pkg::ADDR_CTRL0)
            prdata <= {28'h0000000, run_q, 3'h0};
         else if (paddr == ctm_pkg::ADDR_CTRL1)
            prdata <= {24'h000000, ctrl1_q};
         else if (paddr == ctm_pkg::ADDR_CNT)
            prdata <= {22'h000000, cnt_q};
         else if (paddr == ctm_pkg::ADDR_CMPA)
            prdata <= {22'h000000, cmpa_q};
         else if (paddr == ctm_pkg::ADDR_CMPP)
            prdata <= {29'h00000000, cmpp_q};
         else if (paddr == ctm_pkg::ADDR_FLAGS)
            prdata <= {30'h00000000, match_p_flag_q, match_a_flag_q};
         else
            prdata <= 32'h0000_0000;
      end
   end

   // ***************************************************************
   // Comparators
   // ***************************************************************
   // A compare value zero never matches, so the counter wraps at 3FF
   assign a_eq = (cmpa_q != 10'h000) && (cnt_q == cmpa_q);
   // P looks at the top three counter bits, at the end of that slot
   assign p_eq = (cnt_q[9:7] == cmpp_q - 3'h1) &&
                 (cnt_q[6:0] == 7'h7F);
   assign a_match = run_q && a_eq;
   assign p_match = run_q && p_eq; // P value 0 matches at 3FF overflow

   // Clear source: PWM uses the period register, ignoring clear-select
   always_comb
   begin
      if (mode == ctm_pkg::MODE_PWM)
         cnt_clear = swap ? a_match : p_match;
      else if (clrsel)
         cnt_clear = a_match;
      else
         cnt_clear = p_match;
   end

   // ***************************************************************
   // Counter
   // ***************************************************************
   // Counts while running; stops and holds value when run falls
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_q <= ctm_pkg::CNT_RST;
      else if (run_rise)
         cnt_q <= ctm_pkg::CNT_RST;
      else if (run_q)
      begin
         if (cnt_clear || cnt_q == ctm_pkg::CNT_MAX)
            cnt_q <= ctm_pkg::CNT_RST;
         else
            cnt_q <= cnt_q + 10'h001;
      end
   end

   // ***************************************************************
   // Match flags: set wins over a software clear in the same cycle
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         match_a_flag_q <= 1'b0;
         match_p_flag_q <= 1'b0;
      end
      else
      begin
         // Write one to clear
         if (a_match)
            match_a_flag_q <= 1'b1;
         else if (wr_en && paddr == ctm_pkg::ADDR_FLAGS &&
                  pwdata[ctm_pkg::FLAG_A_POS])
            match_a_flag_q <= 1'b0;
         // P flag suppressed when clear-select picks A outside PWM
         if (p_match && (clrsel == 1'b0 || mode == ctm_pkg::MODE_PWM))
            match_p_flag_q <= 1'b1;
         else if (wr_en && paddr == ctm_pkg::ADDR_FLAGS &&
                  pwdata[ctm_pkg::FLAG_P_POS])
            match_p_flag_q <= 1'b0;
      end
   end

   // ***************************************************************
   // PWM waveform
   // ***************************************************************
   assign p_len = (cmpp_q == 3'h0) ? ctm_pkg::FULL_PERIOD :
                  {2'b00, cmpp_q, 7'h00};
   assign period = swap ? {2'b00, cmpa_q} : p_len;
   assign duty = swap ? p_len : {2'b00, cmpa_q};
   assign cnt_ext = {2'b00, cnt_q};

   // Active while below duty; duty at or past period stays active
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wave_q <= 1'b0;
      else
         wave_q <= (duty >= period) || (cnt_ext < duty);
   end

   // ***************************************************************
   // Compare-match pin state
   // ***************************************************************
   // Only an A match or a run bit rise moves the pin; P matches are ignored here
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pin_q <= 1'b0;
      else if (run_rise)
         pin_q <= olc;
      else if (a_match && mode == ctm_pkg::MODE_CMP)
      begin
         case (pfunc)
            ctm_pkg::PF_LOW: pin_q <= 1'b0;
            ctm_pkg::PF_HIGH: pin_q <= 1'b1;
            ctm_pkg::PF_TOGGLE: pin_q <= !pin_q;
            default: pin_q <= pin_q;
         endcase
      end
   end

   // ***************************************************************
   // Output pin (enable active low while driving)
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         timer_out <= 1'b0;
         timer_out_en <= 1'b1;
      end
      else
      begin
         case (mode)
            ctm_pkg::MODE_CMP:
            begin
               timer_out <= pin_q ^ inv;
               timer_out_en <= 1'b0;
            end
            ctm_pkg::MODE_PWM:
            begin
               // Active level from output control, then inversion
               case (pfunc)
                  ctm_pkg::PF_INACT: timer_out <= !olc ^ inv;
                  ctm_pkg::PF_ACT: timer_out <= olc ^ inv;
                  ctm_pkg::PF_WAVE:
                     timer_out <= (wave_q ? olc : !olc) ^ inv;
                  default: timer_out <= !olc ^ inv; // Undefined code
               endcase
               timer_out_en <= 1'b0;
            end
            default:
            begin
               // Timer mode releases the pin to other functions
               timer_out <= 1'b0;
               timer_out_en <= 1'b1;
            end
         endcase
      end
   end

endmodule : ctm_timer

//--- ctm_timer_sva.sv
module ctm_timer_sva
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic timer_out,
   input wire logic timer_out_en
);
   // ****************************************************
   // Shadow of control state
   // ****************************************************
   logic wr;
   logic [7:0] c1_q;
   logic run_q;
   logic p0_q;
   logic [1:0] age_q;
   logic lvl;
   logic [1:0] md;
   logic [1:0] pf;
   // Only completed writes count; pin level folds in invert
   assign wr = psel & penable & pwrite & pready;
   assign lvl = c1_q[3] ^ c1_q[2];
   assign md = c1_q[7:6];
   assign pf = c1_q[5:4];
   // Age saturates at 3 so settled checks wait out pin latency
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         c1_q <= 8'h00;
         run_q <= 1'b0;
         p0_q <= 1'b1;
         age_q <= 2'h0;
      end
      else
      begin
         age_q <= wr ? 2'h0 : age_q + {1'b0, age_q != 2'h3};
         if (wr && paddr == ctm_pkg::ADDR_CTRL1)
            c1_q <= pwdata[7:0];
         if (wr && paddr == ctm_pkg::ADDR_CTRL0)
            run_q <= pwdata[3];
         if (wr && paddr == ctm_pkg::ADDR_CMPP)
            p0_q <= pwdata[2:0] == 3'h0;
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_cmp_en; age_q == 2'h3 && md == 2'b00 |-> !timer_out_en;
   endproperty
   a_cmp_en: assert property (p_cmp_en) else $error("pin idle");
   property p_tmr_en; age_q == 2'h3 && md == 2'b11 |-> timer_out_en;
   endproperty
   a_tmr_en: assert property (p_tmr_en) else $error("pin driven");
   property p_pwm_en; age_q == 2'h3 && md == 2'b10 |-> !timer_out_en;
   endproperty
   a_pwm_en: assert property (p_pwm_en) else $error("pwm idle");
   property p_init; wr && paddr == ctm_pkg::ADDR_CTRL0 && pwdata[3]
      && !run_q && md == 2'b00 |=> ##[0:1] timer_out == lvl;
   endproperty
   a_init: assert property (p_init) else $error("bad start level");
   property p_none; age_q == 2'h3 && md == 2'b00 && pf == 2'b00
      |-> $stable(timer_out);
   endproperty
   a_none: assert property (p_none) else $error("pin moved");
   property p_act; age_q == 2'h3 && run_q && md == 2'b10 && pf == 2'b01
      |-> timer_out == lvl;
   endproperty
   a_act: assert property (p_act) else $error("not active");
   property p_inact; age_q == 2'h3 && run_q && md == 2'b10
      && pf == 2'b00 |-> timer_out == !lvl;
   endproperty
   a_inact: assert property (p_inact) else $error("not idle");
   property p_full; age_q == 2'h3 && run_q && md == 2'b10 && pf == 2'b10
      && c1_q[1] && p0_q |-> timer_out == lvl;
   endproperty
   a_full: assert property (p_full) else $error("not full");
endmodule : ctm_timer_sva

bind ctm_timer ctm_timer_sva u_ctm_timer_sva (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .timer_out(timer_out), .timer_out_en(timer_out_en));

//--- test_compact_timer_modes.sv
module test_compact_timer_modes;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic timer_out;
   logic timer_out_en;
   logic pin_level;
   logic [31:0] rd_v;
   int fail_count = 0;
   int cmp_count = 0;
   // Free-running bus clock
   always #2.5 pclk = ~pclk;
   ctm_timer u_ctm_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_out(timer_out), .timer_out_en(timer_out_en));
   ctm_pin_load u_ctm_pin_load (.pclk(pclk), .timer_out(timer_out),
      .timer_out_en(timer_out_en), .pin_level(pin_level));
   // ****************************************************
   // Bus and compare helpers
   // ****************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Idle edge at the end keeps two requests from sharing a step
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd_v = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd_v, exp);
   endtask : rd
   // Timer is stopped before mode or pin function changes
   task automatic restart(input logic [7:0] c, input logic [9:0] a,
      input logic [2:0] p);
      apb(1'b1, ctm_pkg::ADDR_CTRL0, 32'h0);
      apb(1'b1, ctm_pkg::ADDR_FLAGS, 32'h3);
      apb(1'b1, ctm_pkg::ADDR_CTRL1, {24'h0, c});
      apb(1'b1, ctm_pkg::ADDR_CMPA, {22'h0, a});
      apb(1'b1, ctm_pkg::ADDR_CMPP, {29'h0, p});
      apb(1'b1, ctm_pkg::ADDR_CTRL0, 32'h8);
   endtask : restart
   // ****************************************************
   // Scenarios
   // ****************************************************
   task automatic t_reset;
      rd(ctm_pkg::ADDR_CTRL1, 32'h0);
      rd(ctm_pkg::ADDR_CNT, 32'h0);
      chk(timer_out_en, 1'b0);
      apb(1'b1, 12'h018, 32'hFF);
      rd(12'h018, 32'h0);
      $display("reset test done");
   endtask : t_reset
   // Clear on A at 300; P at 127 is lower yet must stay silent
   task automatic t_cmp(input logic [1:0] f, input logic o, input logic e);
      restart({2'b00, f, o, 3'h1}, 10'h12C, 3'h1);
      // Pin is launched on the edge just passed: look once it has settled
      @(negedge pclk);
      chk(pin_level, o);
      @(posedge pclk);
      repeat (310) @(posedge pclk);
      chk(pin_level, e);
      rd(ctm_pkg::ADDR_FLAGS, 32'h1);
      apb(1'b0, ctm_pkg::ADDR_CNT, 32'h0);
      chk(rd_v <= 32'h12C, 1'b1);
      $display("compare test done");
   endtask : t_cmp
   task automatic t_clr0;
      logic [31:0] held;
      restart(8'hC0, 10'h000, 3'h1);
      repeat (140) @(posedge pclk);
      chk(timer_out_en, 1'b1);
      rd(ctm_pkg::ADDR_FLAGS, 32'h2);
      apb(1'b0, ctm_pkg::ADDR_CNT, 32'h0);
      chk(rd_v < 32'h80, 1'b1);
      apb(1'b1, ctm_pkg::ADDR_CTRL0, 32'h0);
      apb(1'b0, ctm_pkg::ADDR_CNT, 32'h0);
      held = rd_v;
      repeat (20) @(posedge pclk);
      rd(ctm_pkg::ADDR_CNT, held);
      rd(ctm_pkg::ADDR_FLAGS, 32'h2);
      apb(1'b1, ctm_pkg::ADDR_FLAGS, 32'h3);
      rd(ctm_pkg::ADDR_FLAGS, 32'h0);
      $display("timer test done");
   endtask : t_clr0
   // Waveform spans are whole periods and forced levels are steady, so the high count is phase free
   task automatic t_pwm(input logic [7:0] c, input logic [9:0] a,
      input logic [2:0] p, input int span, input int ones,
      input logic [1:0] fl);
      int n;
      restart(c, a, p);
      repeat (5) @(posedge pclk);
      n = 0;
      // Sample mid-cycle so a pin launched on the edge is never raced
      repeat (span)
      begin
         @(negedge pclk);
         n += int'(pin_level === 1'b1);
      end
      @(posedge pclk);
      chk(n, ones);
      rd(ctm_pkg::ADDR_FLAGS, {30'h0, fl});
      $display("pwm test done");
   endtask : t_pwm
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   // Main sequence
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_cmp(ctm_pkg::PF_LOW, 1'b1, 1'b0);
      t_cmp(ctm_pkg::PF_HIGH, 1'b0, 1'b1);
      t_cmp(ctm_pkg::PF_TOGGLE, 1'b1, 1'b0);
      t_cmp(ctm_pkg::PF_NONE, 1'b1, 1'b1);
      t_clr0();
      t_pwm(8'hA8, 10'h040, 3'h1, 256, 128, 2'h3);
      t_pwm(8'hAB, 10'h12B, 3'h1, 600, 256, 2'h3);
      t_pwm(8'hAA, 10'h009, 3'h0, 40, 40, 2'h1);
      t_pwm(8'h98, 10'h009, 3'h0, 20, 20, 2'h1);
      t_pwm(8'h9C, 10'h009, 3'h0, 20, 0, 2'h1);
      t_pwm(8'h88, 10'h009, 3'h0, 20, 0, 2'h1);
      give_verdict();
   end
   // Hang guard: the whole run needs about 13 us
   initial
   begin
      #50000;
      fail_count++;
      give_verdict();
   end
endmodule : test_compact_timer_modes
